// file: logic/word_bit_test_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "word_bit_test_params.svh"

// Behaviour
// RULE1: Positive test gives a true condition when the selected bit is one.
// RULE2: Inverted test gives a false condition when the selected bit is one.
// RULE3: Bit number is four-digit BCD, zero to fifteen inclusive.
// RULE4: Error flag rises for a non-BCD or out-of-range bit number.
// RULE5: Error flag rises for a bad indirect memory pointer or address past area end.
// RULE6: Program must place another instruction after either test in a rung. The unit does not check this.
// RULE7: Source from io to link areas; bit number also timer/counter or immediate.
// RULE8: Source word is 16 bits; bit zero is its least significant bit.
module word_bit_test_unit
(
    input  wire logic                         clk_sys,
    input  wire logic                         nrst,
    input  wire logic                         start,
    input  wire word_bit_test_pkg::test_op_t  opSel,
    input  wire word_bit_test_pkg::area_t     srcArea,
    input  wire logic                         srcIndirect,
    input  wire logic [`WBT_WORD_W-1:0]       srcPointer,
    input  wire logic [`WBT_WORD_W-1:0]       sourceWord,
    input  wire word_bit_test_pkg::area_t     bitArea,
    input  wire logic                         bitIndirect,
    input  wire logic [`WBT_WORD_W-1:0]       bitPointer,
    input  wire logic [`WBT_WORD_W-1:0]       bitOperand,
    output logic                              done,
    output logic                              execCond,
    output logic                              error_flag
);

    localparam int NCHK = 3;

    logic [`WBT_WORD_W-1:0] chkWord  [NCHK];
    logic                   chkBcd   [NCHK];
    logic [`WBT_BIN_W-1:0]  chkValue [NCHK];

    logic                     bitNumBad;
    logic                     srcPtrBad;
    logic                     bitPtrBad;
    logic                     areaBad;
    logic                     anyError;
    logic [`WBT_BIT_IDX_W-1:0] bitIdx;
    logic                     selected;
    logic                     next_cond;

    // Only memory areas may be reached through a pointer
    function automatic logic pointerBad
    (
        input logic                     indirect,
        input word_bit_test_pkg::area_t area,
        input logic                     isBcd,
        input logic [`WBT_BIN_W-1:0]    addr
    );
        logic bad;
        bad = 1'b0;
        if (indirect)
        begin
            if (area == word_bit_test_pkg::data_memory_area)
            begin
                bad = !isBcd || (addr > `WBT_DM_LAST_ADDR);
            end
            else if (area == word_bit_test_pkg::extended_memory_area)
            begin
                bad = !isBcd || (addr > `WBT_EM_LAST_ADDR);
            end
            else
            begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction

    assign chkWord[0] = bitOperand;
    assign chkWord[1] = srcPointer;
    assign chkWord[2] = bitPointer;

    genvar c;
    generate
        for (c = 0; c < NCHK; c = c + 1)
        begin : g_chk
            bcd_word_check u_chk
            (
                .word  (chkWord[c]),
                .isBcd (chkBcd[c]),
                .value (chkValue[c])
            );
        end
    endgenerate

    // Operand validation
    always_comb
    begin
        bitNumBad = !chkBcd[0] || (chkValue[0] > `WBT_BIT_LAST); // see RULE3 see RULE4
        srcPtrBad = pointerBad(srcIndirect, srcArea, chkBcd[1], chkValue[1]); // see RULE5
        bitPtrBad = pointerBad(bitIndirect, bitArea, chkBcd[2], chkValue[2]); // see RULE5
        // Source may not be a timer/counter or a constant
        areaBad   = (srcArea == word_bit_test_pkg::timer_counter_area)
                 || (srcArea == word_bit_test_pkg::immediate_area)
                 || (srcArea > word_bit_test_pkg::immediate_area)
                 || (bitArea > word_bit_test_pkg::immediate_area); // see RULE7
        anyError  = bitNumBad || srcPtrBad || bitPtrBad || areaBad;
    end

    // Bit selection and polarity
    always_comb
    begin
        bitIdx   = chkValue[0][`WBT_BIT_IDX_W-1:0];
        selected = sourceWord[bitIdx]; // see RULE8
        if (anyError)
        begin
            // A faulted test never enables what follows it
            next_cond = 1'b0;
        end
        else if (opSel == word_bit_test_pkg::bit_test_inverted)
        begin
            next_cond = !selected; // see RULE2
        end
        else
        begin
            next_cond = selected; // see RULE1
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= start;
        end
    end

    // Result holds until the next executed test
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            execCond <= `WBT_COND_RESET;
        end
        else if (start)
        begin
            execCond <= next_cond; // see RULE1 see RULE2
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            error_flag <= `WBT_ERROR_RESET;
        end
        else if (start)
        begin
            error_flag <= anyError; // see RULE4 see RULE5
        end
    end

    // Reference bit index decoded straight from the two low BCD digits
    logic [`WBT_BIT_IDX_W-1:0] refIdx;
    logic                      refClean;

    assign refIdx   = bitOperand[4] ? bitOperand[3:0] + 4'hA : bitOperand[3:0];
    assign refClean = (bitOperand[15:5] == 11'h000) && (bitOperand[3:0] <= 4'h9)
                   && !(bitOperand[4] && bitOperand[3:0] > 4'h5)
                   && !srcIndirect && !bitIndirect
                   && (srcArea == word_bit_test_pkg::io_area)
                   && (bitArea == word_bit_test_pkg::immediate_area);

    a_true_polarity: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE1
        start && refClean && opSel == word_bit_test_pkg::bit_test_true
        |=> execCond == $past(sourceWord[refIdx]) && !error_flag)
        else $error("positive test result wrong");

    a_inverted_polarity: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE2
        start && refClean && opSel == word_bit_test_pkg::bit_test_inverted
        |=> execCond == !$past(sourceWord[refIdx]) && !error_flag)
        else $error("inverted test result wrong");

    a_bit_range_error: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE3
        start && bitOperand[15:4] == 12'h001 && bitOperand[3:0] > 4'h5
        |=> error_flag && !execCond)
        else $error("bit number above fifteen not flagged");

    a_nonbcd_error: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE4
        start && (bitOperand[3:0] > 4'h9 || bitOperand[11:8] > 4'h9)
        |=> error_flag)
        else $error("non-BCD bit number not flagged");

    a_pointer_error: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE5
        start && srcIndirect && srcArea == word_bit_test_pkg::data_memory_area
        && srcPointer[7:4] > 4'h9
        |=> error_flag)
        else $error("bad indirect pointer not flagged");

    a_source_area: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE7
        start && srcArea == word_bit_test_pkg::timer_counter_area
        |=> error_flag ##1 (error_flag || $past(start)))
        else $error("timer area source not flagged");

    a_msb_select: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE8
        start && refClean && bitOperand == 16'h0015
        && opSel == word_bit_test_pkg::bit_test_true
        |=> execCond == $past(sourceWord[15]))
        else $error("bit fifteen not the top bit");

    a_result_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE1
        !start |=> $stable(execCond) && $stable(error_flag) && !done)
        else $error("result changed without a test");

    c_true_hit: cover property (@(posedge clk_sys) disable iff (!nrst)
        start && refClean && opSel == word_bit_test_pkg::bit_test_true ##1 execCond);

    c_inverted_hit: cover property (@(posedge clk_sys) disable iff (!nrst)
        start && refClean && opSel == word_bit_test_pkg::bit_test_inverted ##1 execCond);

    c_error_seen: cover property (@(posedge clk_sys) disable iff (!nrst)
        start ##1 error_flag);

    c_back_to_back: cover property (@(posedge clk_sys) disable iff (!nrst)
        start [*3]);

endmodule
`default_nettype wire

// file: inc/word_bit_test_params.svh
`ifndef WORD_BIT_TEST_PARAMS_SVH
`define WORD_BIT_TEST_PARAMS_SVH

// Operand and word geometry
`define WBT_WORD_W        16
`define WBT_BIT_IDX_W     4
`define WBT_BIN_W         14
`define WBT_DIGITS        4
`define WBT_DIGIT_W       4
`define WBT_DIGIT_MAX     4'h9

// Highest legal bit number, binary form of BCD 0015
`define WBT_BIT_LAST      14'h000F

// Last addressable word of the indirectly addressed areas
`define WBT_DM_LAST_ADDR  14'h19FF
`define WBT_EM_LAST_ADDR  14'h17FF

// Reset values of the result
`define WBT_COND_RESET    1'b0
`define WBT_ERROR_RESET   1'b0

`endif

// file: inc/word_bit_test_pkg.sv
package word_bit_test_pkg;

    typedef enum logic [3:0] {
        io_area,
        special_area,
        auxiliary_area,
        data_memory_area,
        extended_memory_area,
        holding_area,
        link_area,
        timer_counter_area,
        immediate_area
    } area_t;

    typedef enum logic {
        bit_test_true,
        bit_test_inverted
    } test_op_t;

endpackage

// file: logic/bcd_word_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "word_bit_test_params.svh"

// Checks a four-digit BCD word and converts it to binary
module bcd_word_check
(
    input  wire logic [`WBT_WORD_W-1:0] word,
    output logic                        isBcd,
    output logic      [`WBT_BIN_W-1:0]  value
);

    logic [`WBT_DIGITS-1:0] digitOk;

    genvar d;
    generate
        for (d = 0; d < `WBT_DIGITS; d = d + 1)
        begin : g_digit
            assign digitOk[d] = word[d*`WBT_DIGIT_W +: `WBT_DIGIT_W] <= `WBT_DIGIT_MAX;
        end
    endgenerate

    assign isBcd = &digitOk;

    // Max 9999 fits in 14 bits
    assign value = 14'(word[15:12]) * 14'h03E8
                 + 14'(word[11:8])  * 14'h0064
                 + 14'(word[7:4])   * 14'h000A
                 + 14'(word[3:0]);

endmodule
`default_nettype wire

// file: sim/word_bit_test_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "word_bit_test_params.svh"

module word_bit_test_unit_tb_top;
    logic                        clk_sys = 1'b0;
    logic                        nrst = 1'b0;
    logic                        start = 1'b0;
    word_bit_test_pkg::test_op_t opSel = word_bit_test_pkg::bit_test_true;
    word_bit_test_pkg::area_t    srcArea = word_bit_test_pkg::io_area;
    word_bit_test_pkg::area_t    bitArea = word_bit_test_pkg::immediate_area;
    logic                        srcIndirect = 1'b0;
    logic                        bitIndirect = 1'b0;
    logic [`WBT_WORD_W-1:0]      srcPointer = 16'h0000;
    logic [`WBT_WORD_W-1:0]      bitPointer = 16'h0000;
    logic [`WBT_WORD_W-1:0]      sourceWord = 16'h0000;
    logic [`WBT_WORD_W-1:0]      bitOperand = 16'h0000;
    logic                        done;
    logic                        execCond;
    logic                        error_flag;
    int                          failures = 0;
    int                          n_checks = 0;

    localparam word_bit_test_pkg::test_op_t opTrue = word_bit_test_pkg::bit_test_true;
    localparam word_bit_test_pkg::test_op_t opInv  = word_bit_test_pkg::bit_test_inverted;

    always #4 clk_sys = ~clk_sys;

    word_bit_test_unit DUT (.clk_sys(clk_sys), .nrst(nrst), .start(start), .opSel(opSel),
        .srcArea(srcArea), .srcIndirect(srcIndirect), .srcPointer(srcPointer),
        .sourceWord(sourceWord), .bitArea(bitArea), .bitIndirect(bitIndirect),
        .bitPointer(bitPointer), .bitOperand(bitOperand), .done(done),
        .execCond(execCond), .error_flag(error_flag));

    task automatic chk(input string name, input logic expV, input logic got);
        n_checks++;
        if (got !== expV)
        begin
            failures++;
            $display("[ERR] %s expected %b seen %b", name, expV, got);
        end
    endtask

    task automatic drive(input word_bit_test_pkg::test_op_t op, input int sa,
                         input logic si, input logic [15:0] sp, input logic [15:0] w,
                         input int ba, input logic bi, input logic [15:0] bo);
        opSel <= op;
        srcArea <= word_bit_test_pkg::area_t'(sa);
        srcIndirect <= si;
        srcPointer <= sp;
        sourceWord <= w;
        bitArea <= word_bit_test_pkg::area_t'(ba);
        bitIndirect <= bi;
        bitPointer <= sp;
        bitOperand <= bo;
        start <= 1'b1;
    endtask

    task automatic go(input word_bit_test_pkg::test_op_t op, input int sa, input logic si,
                      input logic [15:0] sp, input logic [15:0] w, input int ba,
                      input logic bi, input logic [15:0] bo, input logic c, input logic e);
        @(posedge clk_sys);
        drive(op, sa, si, sp, w, ba, bi, bo);
        @(posedge clk_sys);
        // Start is held for one clock only; done and the result are checked just after the next edge
        start <= 1'b0;
        #1;
        chk("done", 1'b1, done);
        chk("execCond", c, execCond);
        chk("error_flag", e, error_flag);
    endtask

    task automatic test_bit_select;
        logic [15:0] bo;
        for (int b = 0; b < 16; b++)
        begin
            bo = 16'((b / 10) * 16 + b % 10);
            go(opTrue, b % 7, 0, 0, 16'h0001 << b, 8, 0, bo, 1, 0);
            go(opTrue, b % 7, 0, 0, ~(16'h0001 << b), 7, 0, bo, 0, 0);
            go(opInv, b % 7, 0, 0, 16'h0001 << b, 8, 0, bo, 0, 0);
            go(opInv, b % 7, 0, 0, ~(16'h0001 << b), 0, 0, bo, 1, 0);
        end
    endtask

    task automatic test_bad_bit_number;
        logic [15:0] bad [5] = '{16'h000A, 16'h0016, 16'h0099, 16'h00F0, 16'h1000};
        foreach (bad[i])
            go(opTrue, 0, 0, 0, 16'hFFFF, 8, 0, bad[i], 0, 1);
        go(opInv, 0, 0, 0, 16'h7FFF, 8, 0, 16'h0015, 1, 0);
    endtask

    task automatic test_pointer;
        logic [15:0] ptr [6] = '{16'h6655, 16'h6656, 16'h1A00, 16'h6143, 16'h6144, 16'h0000};
        int          ar [6] = '{3, 3, 3, 4, 4, 5};
        logic        er [6] = '{0, 1, 1, 0, 1, 1};
        foreach (ptr[i])
            go(opTrue, ar[i], 1, ptr[i], 16'h0001, 8, 0, 0, !er[i], er[i]);
        go(opTrue, 0, 0, 16'h6656, 16'h0001, 3, 1, 0, 0, 1);
        go(opTrue, 7, 0, 0, 16'h0001, 8, 0, 0, 0, 1);
        go(opTrue, 8, 0, 0, 16'h0001, 8, 0, 0, 0, 1);
    endtask

    task automatic test_back_to_back_and_reset;
        @(posedge clk_sys);
        drive(opTrue, 0, 0, 0, 16'h8000, 8, 0, 16'h0015);
        @(posedge clk_sys);
        drive(opTrue, 0, 0, 0, 16'h8000, 8, 0, 16'h0016);
        #1;
        chk("execCond first", 1'b1, execCond);
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        chk("done second", 1'b1, done);
        chk("error second", 1'b1, error_flag);
        chk("execCond second", 1'b0, execCond);
        go(opInv, 0, 0, 0, 16'h0000, 8, 0, 0, 1, 0);
        @(posedge clk_sys);
        nrst <= 1'b0;
        @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        chk("execCond reset", 1'b0, execCond);
        chk("done reset", 1'b0, done);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #20000;
        failures++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        chk("error_flag reset", 1'b0, error_flag);
        chk("execCond start", 1'b0, execCond);
        chk("done start", 1'b0, done);
        test_bit_select();
        test_bad_bit_number();
        test_pointer();
        test_back_to_back_and_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
